// >>> breakpoint_trigger_and_trace.sv
// breakpoint registers, trigger sequencer and trace outputs
`timescale 1ns/1ps
`include "dbg_defines.svh"
module breakpoint_trigger_and_trace #(
	parameter bit FULL_TRACE = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic debug_serial_in,
	input wire logic debug_serial_clock,
	output logic debug_serial_out,
	input wire logic cpu_sel,
	input wire logic cpu_write,
	input wire logic cpu_super,
	input wire logic [3:0] cpu_index,
	input wire logic [31:0] cpu_wdata,
	output logic [31:0] cpu_rdata,
	output logic cpu_ack,
	output logic cpu_err,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_data,
	input wire logic pc_valid,
	input wire logic [31:0] pc_value,
	input wire logic core_rte,
	input wire logic [2:0] int_level,
	input wire logic [3:0] core_status,
	input wire logic [3:0] core_capture,
	output logic halt_req,
	output logic debug_irq,
	output logic int_pass,
	output logic [3:0] processor_status_bus,
	output logic [3:0] debug_capture_bus,
	output logic trace_clock_out,
	output logic halted_indicator
);
	import dbg_pkg::*;

	// ****************************************
	// storage and wiring
	// ****************************************
	logic [31:0] bp [`BP_COUNT]; // breakpoint compare and mask registers
	logic [`CFG_WIDTH-1:0] cfg; // trigger configuration
	trig_state_e state; // sequencer state
	trig_state_e next_state;
	logic reply_load; // serial read answer ready
	logic [31:0] reply_data;

	cmd_if ser2buf ();
	cmd_if buf2core ();

	serial_port u_serial (
		.clk(clk),
		.sys_rst(sys_rst),
		.serial_in(debug_serial_in),
		.serial_clock(debug_serial_clock),
		.serial_out(debug_serial_out),
		.reply_load(reply_load),
		.reply_data(reply_data),
		.cmd_out(ser2buf)
	);

	cmd_buffer #(.DEPTH(2)) u_buffer (
		.clk(clk),
		.sys_rst(sys_rst),
		.fill(ser2buf),
		.drain(buf2core)
	);

	// ****************************************
	// access arbitration
	// ****************************************
	// supervisor accesses win; the serial command waits in the buffer
	wire cpu_take = cpu_sel && cpu_super && !cpu_ack;
	assign buf2core.ready = !cpu_take;
	wire ser_take = buf2core.valid && !cpu_take;
	wire wr_en = cpu_take ? cpu_write : (ser_take && buf2core.cmd.write);
	wire [3:0] acc_idx = cpu_take ? cpu_index : buf2core.cmd.index;
	wire [31:0] acc_data = cpu_take ? cpu_wdata : buf2core.cmd.data;
	wire acc_bp = (acc_idx < `IDX_TRIG_CFG);
	wire acc_cfg = (acc_idx == `IDX_TRIG_CFG);
	wire [31:0] cfg_word = {{(32-`CFG_WIDTH){1'b0}}, cfg};
	// unmapped indices read as zero
	wire [31:0] rd_word = acc_bp ? bp[acc_idx] : (acc_cfg ? cfg_word : 32'h0000_0000);

	// ****************************************
	// match logic
	// ****************************************
	// masked compare
	wire addr_hit = bus_valid &&
		(((bus_addr ^ bp[`IDX_ADDR_CMP]) & bp[`IDX_ADDR_MSK]) == 32'h0000_0000);
	wire data_hit = bus_valid &&
		(((bus_data ^ bp[`IDX_DATA_CMP]) & bp[`IDX_DATA_MSK]) == 32'h0000_0000);
	logic [3:0] pc_hits;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pc
			assign pc_hits[g] = pc_valid &&
				(((pc_value ^ bp[`IDX_PC_CMP0 + g]) & bp[`IDX_PC_MSK]) == 32'h0000_0000);
		end
	endgenerate
	wire pc_hit = |pc_hits;
	wire [2:0] hits = {pc_hit, data_hit, addr_hit};
	wire [2:0] l1_en = cfg[`CFG_L1_LSB +: 3];
	wire [2:0] l2_en = cfg[`CFG_L2_LSB +: 3];
	wire l1_hit = (l1_en != 3'h0) && (&(~l1_en | hits));
	wire l2_hit = (l2_en != 3'h0) && (&(~l2_en | hits));
	wire armed = cfg[`CFG_ARM];
	wire two_level = cfg[`CFG_TWO_LEVEL];
	wire act_irq = cfg[`CFG_ACT_IRQ];
	wire [2:0] crit_level = cfg[`CFG_CRIT_LSB +: 3];

	// ****************************************
	// trigger sequencer
	// ****************************************
	// one or two level sequencing
	// a config write dropping arm in the matching cycle does not cancel the action
	wire fire = armed && ((state == st_level1 && l1_hit && !two_level) ||
		(state == st_level2 && l2_hit));
	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (armed) begin
					next_state = st_level1;
				end
			end
			st_level1: begin
				if (!armed) begin
					next_state = st_idle;
				end else if (l1_hit && two_level) begin
					next_state = st_level2;
				end else if (fire) begin
					next_state = act_irq ? st_dbg_int : st_idle;
				end
			end
			st_level2: begin
				if (!armed) begin
					next_state = st_idle;
				end else if (fire) begin
					next_state = act_irq ? st_dbg_int : st_idle;
				end
			end
			st_dbg_int: begin
				// stays until the handler returns
				if (core_rte) begin
					next_state = st_idle;
				end
			end
			default: next_state = st_idle;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= st_idle;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// register file writes
	// ****************************************
	// nine breakpoint words
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `BP_COUNT; i++) begin
				bp[i] <= `BP_RESET;
			end
		end else if (wr_en && acc_bp) begin
			bp[acc_idx] <= acc_data;
		end
	end

	// config; firing disarms so one setup fires once, software write wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg <= `CFG_RESET;
		end else if (wr_en && acc_cfg) begin
			cfg <= acc_data[`CFG_WIDTH-1:0];
		end else if (fire) begin
			cfg[`CFG_ARM] <= 1'b0;
		end
	end

	// ****************************************
	// read answers
	// ****************************************
	// user mode accesses refused
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cpu_rdata <= 32'h0000_0000;
			cpu_ack <= 1'b0;
			cpu_err <= 1'b0;
			reply_load <= 1'b0;
			reply_data <= 32'h0000_0000;
		end else begin
			cpu_ack <= cpu_sel && !cpu_ack;
			cpu_err <= cpu_sel && !cpu_super && !cpu_ack;
			cpu_rdata <= cpu_take ? rd_word : 32'h0000_0000;
			reply_load <= ser_take && !buf2core.cmd.write;
			reply_data <= rd_word;
		end
	end

	// ****************************************
	// trigger actions
	// ****************************************
	// halt or debug interrupt
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			halt_req <= 1'b0;
			debug_irq <= 1'b0;
			int_pass <= 1'b0;
		end else begin
			halt_req <= fire && !act_irq;
			debug_irq <= fire && act_irq;
			int_pass <= (state == st_dbg_int) && (int_level >= crit_level);
		end
	end

	// ****************************************
	// trace outputs
	// ****************************************
	// full buses only on largest package
	wire [3:0] status_src = FULL_TRACE ? core_status : 4'h0;
	wire [3:0] cap_src = FULL_TRACE ? core_capture : 4'h0;
	// status and capture at core rate
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			processor_status_bus <= 4'h0;
			debug_capture_bus <= 4'h0;
			trace_clock_out <= 1'b0;
			halted_indicator <= 1'b0;
		end else begin
			processor_status_bus <= status_src;
			debug_capture_bus <= cap_src;
			trace_clock_out <= FULL_TRACE ? !trace_clock_out : 1'b0;
			halted_indicator <= (core_status == `HALT_CODE);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_halted;
		##1 halted_indicator == (&$past(core_status));
	endproperty
	a_halted: assert property (p_halted) else $error("halted indicator wrong");
	property p_status_copy;
		FULL_TRACE |=> processor_status_bus == $past(core_status);
	endproperty
	a_status_copy: assert property (p_status_copy) else $error("status bus not following");
	// sampled reset in the antecedent keeps the release edge out
	property p_capture_copy;
		FULL_TRACE && !sys_rst |=> debug_capture_bus == $past(core_capture);
	endproperty
	a_capture_copy: assert property (p_capture_copy) else $error("capture bus not following");
	property p_trace_clock;
		FULL_TRACE && !sys_rst |=> trace_clock_out != $past(trace_clock_out);
	endproperty
	a_trace_clock: assert property (p_trace_clock) else $error("trace clock stuck");
	property p_no_trace;
		!FULL_TRACE |-> processor_status_bus == 4'h0 && debug_capture_bus == 4'h0;
	endproperty
	a_no_trace: assert property (p_no_trace) else $error("trace on small package");
	property p_halt_act;
		fire && !act_irq |=> halt_req && !debug_irq ##1 !halt_req;
	endproperty
	a_halt_act: assert property (p_halt_act) else $error("halt not raised once");
	property p_irq_act;
		fire && act_irq |=> debug_irq && state == st_dbg_int;
	endproperty
	a_irq_act: assert property (p_irq_act) else $error("debug interrupt missing");
	property p_two_level;
		state == st_level1 && two_level && l1_hit && armed |=> state == st_level2 && !halt_req;
	endproperty
	a_two_level: assert property (p_two_level) else $error("second level skipped");
	property p_crit;
		state == st_dbg_int && int_level >= crit_level |=> int_pass;
	endproperty
	a_crit: assert property (p_crit) else $error("critical interrupt blocked");
	property p_user_refused;
		cpu_sel && !cpu_super && !cpu_ack && cpu_write |=> cpu_err && $stable(cfg);
	endproperty
	a_user_refused: assert property (p_user_refused) else $error("user write taken");
	property p_bp_write;
		cpu_take && cpu_write && acc_bp |=> bp[$past(cpu_index)] == $past(cpu_wdata);
	endproperty
	a_bp_write: assert property (p_bp_write) else $error("breakpoint write lost");
	property p_mask;
		bus_valid && bp[`IDX_ADDR_MSK] == 32'h0000_0000 |-> addr_hit;
	endproperty
	a_mask: assert property (p_mask) else $error("masked bits compared");

	c_halt: cover property (halt_req);
	c_irq_rte: cover property (debug_irq ##[1:50] core_rte);
	c_serial_read: cover property (reply_load);
	c_two_level: cover property (state == st_level2);
endmodule

// >>> cmd_buffer.sv
// two-entry command buffer with valid/ready on both sides
`timescale 1ns/1ps
module cmd_buffer #(
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	cmd_if.snk fill,
	cmd_if.src drain
);
	import dbg_pkg::*;
	localparam int PW = $clog2(DEPTH);

	cmd_s mem [DEPTH]; // entry storage
	logic [PW-1:0] wr_ptr; // next slot to fill
	logic [PW-1:0] rd_ptr; // oldest slot
	logic [PW:0] count; // occupancy

	wire push = fill.valid && fill.ready;
	wire pop = drain.valid && drain.ready;
	// full refuses the source, so a stalled sink never loses a word
	assign fill.ready = (count != (PW+1)'(DEPTH));
	assign drain.valid = (count != '0);
	assign drain.cmd = mem[rd_ptr];

	// ****************************************
	// pointers and occupancy
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// storage write, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= fill.cmd;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_no_overfill;
		count <= (PW+1)'(DEPTH);
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("buffer overfilled");
	property p_full_fill;
		(count == (PW+1)'(DEPTH)) |-> !fill.ready;
	endproperty
	a_full_fill: assert property (p_full_fill) else $error("full buffer accepts");
	c_full: cover property (count == (PW+1)'(DEPTH));
endmodule

// >>> cmd_if.sv
// command stream carrier between serial port, buffer and register file
`timescale 1ns/1ps
interface cmd_if;
	import dbg_pkg::*;
	logic valid; // command offered
	logic ready; // command accepted
	cmd_s cmd; // command payload
	modport src (output valid, output cmd, input ready);
	modport snk (input valid, input cmd, output ready);
endinterface

// >>> dbg_defines.svh
// constants for the breakpoint, trigger and trace block
//
// Functional notes
// - nine 32-bit breakpoint compare and mask registers
// - registers reachable serially and from supervisor mode
// - address, data, pc matches form 1/2-level triggers
// - trigger halts core or raises debug interrupt
// - critical interrupts still served during debug interrupt
// - 4-bit status, 4-bit capture buses, trace clock
// - halted indicator is AND of status bits
// - serial channel always; full trace only largest package
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH

// ****************************************
// register indices
// ****************************************
`define IDX_ADDR_CMP 4'h0
`define IDX_ADDR_MSK 4'h1
`define IDX_DATA_CMP 4'h2
`define IDX_DATA_MSK 4'h3
`define IDX_PC_CMP0 4'h4
`define IDX_PC_MSK 4'h8
`define IDX_TRIG_CFG 4'h9
`define BP_COUNT 9
`define BP_RESET 32'h0000_0000

// ****************************************
// trigger configuration fields
// ****************************************
`define CFG_L1_LSB 0
`define CFG_L2_LSB 3
`define CFG_TWO_LEVEL 6
`define CFG_ACT_IRQ 7
`define CFG_ARM 8
`define CFG_CRIT_LSB 9
`define CFG_WIDTH 12
`define CFG_RESET 12'h000

// ****************************************
// serial frame layout
// ****************************************
`define FRAME_BITS 37
`define FRAME_CNT_W 6
`define FRAME_WR_BIT 36
`define FRAME_IDX_LSB 32
`define HALT_CODE 4'hF

`endif

// >>> dbg_pkg.sv
// shared types for the breakpoint, trigger and trace block
package dbg_pkg;
	// one debug command taken from the serial channel
	typedef struct packed {
		logic write;
		logic [3:0] index;
		logic [31:0] data;
	} cmd_s;

	// trigger sequencer states, one-hot
	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_level1 = 4'b0010,
		st_level2 = 4'b0100,
		st_dbg_int = 4'b1000
	} trig_state_e;
endpackage

// >>> debug_tool.sv
// behavioural debug tool on the three-wire serial channel
`timescale 1ns/1ps
module debug_tool (
	output logic serial_clock,
	output logic serial_data,
	input wire logic serial_reply
);
	// ****************************************
	// link idle state
	// ****************************************
	// clock stands low between frames, as the block expects at reset release
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
	end

	// ****************************************
	// frame shifter
	// ****************************************
	// serial channel access
	// one 37-bit frame msb first; the reply of the previous read comes back meanwhile
	task automatic frame(input logic [36:0] bits, output logic [31:0] reply);
		for (int i = 36; i >= 0; i--) begin
			serial_data = bits[i];
			#80;
			// reply bit is steady at our rising edge
			if (i > 4) reply[i - 5] = serial_reply;
			serial_clock = 1'b1;
			#80;
			serial_clock = 1'b0;
		end
		// released line shows the inverse, never a stale copy
		serial_data = ~serial_data;
	endtask
endmodule

// >>> serial_port.sv
// three-wire serial debug channel: frame receiver and reply shifter
`timescale 1ns/1ps
`include "dbg_defines.svh"
module serial_port (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic serial_in,
	input wire logic serial_clock,
	output logic serial_out,
	input wire logic reply_load,
	input wire logic [31:0] reply_data,
	cmd_if.src cmd_out
);
	import dbg_pkg::*;

	logic [1:0] din_sync; // pin synchroniser for data
	logic [1:0] clk_sync; // pin synchroniser for serial clock
	logic clk_prev; // last synchronised clock level
	logic [`FRAME_BITS-1:0] shift_in; // incoming frame
	logic [`FRAME_CNT_W-1:0] bit_cnt; // bits taken this frame
	logic pending; // frame waiting for the buffer
	logic [31:0] shift_out; // reply being shifted out
	logic reply_fresh; // loaded msb not yet passed a rising edge

	wire rise = clk_sync[1] && !clk_prev;
	wire fall = !clk_sync[1] && clk_prev;
	wire last_bit = (bit_cnt == `FRAME_CNT_W'(`FRAME_BITS-1));
	assign cmd_out.valid = pending;
	assign cmd_out.cmd = shift_in;

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			din_sync <= 2'h0;
			clk_sync <= 2'h0;
			clk_prev <= 1'b0;
		end else begin
			din_sync <= {din_sync[0], serial_in};
			clk_sync <= {clk_sync[0], serial_clock};
			clk_prev <= clk_sync[1];
		end
	end

	// ****************************************
	// receive side, msb first on rising edges
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_in <= '0;
			bit_cnt <= '0;
			pending <= 1'b0;
		end else if (pending) begin
			// edges while a frame waits are ignored: the tool must pace itself
			pending <= !cmd_out.ready;
		end else if (rise) begin
			shift_in <= {shift_in[`FRAME_BITS-2:0], din_sync[1]};
			bit_cnt <= last_bit ? '0 : bit_cnt + 1'b1;
			pending <= last_bit;
		end
	end

	// ****************************************
	// reply side, changes on falling edges
	// ****************************************
	// the falling edge closing the read frame lands after the load; shifting
	// on it would lose the msb before the tool's next rising edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_out <= '0;
			serial_out <= 1'b0;
			reply_fresh <= 1'b0;
		end else if (reply_load) begin
			shift_out <= reply_data;
			serial_out <= reply_data[31];
			reply_fresh <= 1'b1;
		end else if (rise) begin
			reply_fresh <= 1'b0;
		end else if (fall && !reply_fresh) begin
			shift_out <= {shift_out[30:0], 1'b0};
			serial_out <= shift_out[30];
		end
	end
endmodule

// >>> tb.sv
// self-checking bench for the breakpoint, trigger and trace block
`timescale 1ns/1ps
module tb;
	// ****************************************
	// signals, named as the ports so .* binds them
	// ****************************************
	logic clk, sys_rst, debug_serial_in, debug_serial_clock, debug_serial_out;
	logic cpu_sel, cpu_write, cpu_super, cpu_ack, cpu_err, bus_valid, pc_valid, core_rte;
	logic halt_req, debug_irq, int_pass, trace_clock_out, halted_indicator, small_halted;
	logic [2:0] int_level;
	logic [3:0] cpu_index, core_status, core_capture, processor_status_bus, debug_capture_bus;
	logic [3:0] small_status;
	logic [31:0] cpu_wdata, cpu_rdata, bus_addr, bus_data, pc_value;
	int bad_count = 0; // mismatches
	int tests_run = 0; // comparisons

	// full package, plus a small package that shares every input
	breakpoint_trigger_and_trace breakpoint_trigger_and_trace_i (.*);
	breakpoint_trigger_and_trace #(.FULL_TRACE(1'b0)) small_i (.*, .debug_serial_out(),
		.cpu_rdata(), .cpu_ack(), .cpu_err(), .halt_req(), .debug_irq(), .int_pass(),
		.processor_status_bus(small_status), .debug_capture_bus(), .trace_clock_out(),
		.halted_indicator(small_halted));
	debug_tool debug_tool_i (.serial_clock(debug_serial_clock), .serial_data(debug_serial_in),
		.serial_reply(debug_serial_out));

	// ****************************************
	// shared tasks
	// ****************************************
	// closing report, the only exit
	task automatic results();
		$display("mismatches %0d, comparisons %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// compare with four-state equality so an unknown never matches
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	// one register access; request held until the acknowledge is sampled
	task automatic cpu(input logic w, input logic s, input logic [3:0] i, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		cpu_sel <= 1'b1;
		cpu_write <= w;
		cpu_super <= s;
		cpu_index <= i;
		cpu_wdata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_ack !== 1'b1 && n < 8);
		if (cpu_ack !== 1'b1) begin
			bad_count++;
			$display("wrong value at %0t: no acknowledge", $time);
			results();
		end
		r = cpu_rdata;
		e = cpu_err;
		cpu_sel <= 1'b0;
	endtask

	// one-cycle bus and pc strobe with the same value; returns {halt, irq} one cycle later
	task automatic strobe(input logic b, input logic p, input logic [31:0] v,
		output logic [1:0] seen);
		@(posedge clk);
		bus_valid <= b;
		pc_valid <= p;
		bus_addr <= v;
		bus_data <= v;
		pc_value <= v;
		@(posedge clk);
		bus_valid <= 1'b0;
		pc_valid <= 1'b0;
		@(posedge clk);
		seen = {halt_req, debug_irq};
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	// reset values, supervisor access, user-mode refusal, unmapped slots
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 10; i++) begin
			cpu(1'b0, 1'b1, i[3:0], 32'h0, r, e);
			check(r, 32'h0, "reset value");
		end
		for (int i = 0; i < 13; i++) cpu(1'b1, 1'b1, i[3:0], 32'h8765_4000 | i, r, e);
		for (int i = 0; i < 13; i++) begin
			cpu(1'b0, 1'b1, i[3:0], 32'h0, r, e);
			// config keeps 12 bits, slots past it read zero
			check(r, i > 9 ? 32'h0 : i == 9 ? 32'h9 : 32'h8765_4000 | i, "readback");
		end
		cpu(1'b1, 1'b0, 4'h0, 32'h1111_1111, r, e);
		check(e, 1'b1, "user write error");
		cpu(1'b0, 1'b0, 4'h0, 32'h0, r, e);
		check(e, 1'b1, "user read error");
		check(r, 32'h0, "user read data");
		cpu(1'b0, 1'b1, 4'h0, 32'h0, r, e);
		check(r, 32'h8765_4000, "user write ignored");
	endtask

	// back-to-back serial writes, then a serial read of a processor-written word
	task automatic t_serial();
		logic [31:0] r, q;
		logic e;
		debug_tool_i.frame({1'b1, 4'h5, 32'hCAFE_0005}, q);
		debug_tool_i.frame({1'b1, 4'h6, 32'hBEEF_0006}, q);
		repeat (20) @(posedge clk);
		cpu(1'b0, 1'b1, 4'h5, 32'h0, r, e);
		check(r, 32'hCAFE_0005, "first serial write");
		cpu(1'b0, 1'b1, 4'h6, 32'h0, r, e);
		check(r, 32'hBEEF_0006, "second serial write");
		debug_tool_i.frame({1'b0, 4'h0, 32'h0}, q);
		repeat (20) @(posedge clk);
		debug_tool_i.frame({1'b0, 4'hF, 32'h0}, q);
		check(q, 32'h8765_4000, "serial read");
	endtask

	// single-level address trigger with a mask, halting once
	task automatic t_halt();
		logic [31:0] r;
		logic e;
		logic [1:0] s;
		cpu(1'b1, 1'b1, 4'h0, 32'h1234_5678, r, e);
		cpu(1'b1, 1'b1, 4'h1, 32'hFFFF_FF00, r, e);
		cpu(1'b1, 1'b1, 4'h9, 32'h0000_0101, r, e);
		repeat (2) @(posedge clk);
		strobe(1'b1, 1'b0, 32'h1234_5778, s);
		check(s, 2'b00, "compared bit differs");
		strobe(1'b1, 1'b0, 32'h1234_56AB, s);
		check(s, 2'b10, "masked bits ignored");
		@(posedge clk);
		check(halt_req, 1'b0, "halt is one pulse");
		strobe(1'b1, 1'b0, 32'h1234_5678, s);
		check(s, 2'b00, "disarmed after fire");
		cpu(1'b0, 1'b1, 4'h9, 32'h0, r, e);
		check(r, 32'h1, "arm cleared");
		// a clear mask makes every address match
		cpu(1'b1, 1'b1, 4'h1, 32'h0000_0000, r, e);
		cpu(1'b1, 1'b1, 4'h9, 32'h0000_0101, r, e);
		repeat (2) @(posedge clk);
		strobe(1'b1, 1'b0, 32'h0BAD_F00D, s);
		check(s, 2'b10, "clear mask matches all");
	endtask

	// two-level pc then data trigger raising the debug interrupt
	task automatic t_irq();
		logic [31:0] r;
		logic e;
		logic [1:0] s;
		cpu(1'b1, 1'b1, 4'h7, 32'h0000_4000, r, e);
		cpu(1'b1, 1'b1, 4'h8, 32'hFFFF_FFFF, r, e);
		cpu(1'b1, 1'b1, 4'h2, 32'h0000_D000, r, e);
		cpu(1'b1, 1'b1, 4'h3, 32'hFFFF_FFFF, r, e);
		// level1 pc, level2 data, two-level, irq, armed, critical level 5
		cpu(1'b1, 1'b1, 4'h9, 32'h0000_0BD4, r, e);
		repeat (2) @(posedge clk);
		strobe(1'b1, 1'b0, 32'h0000_D000, s);
		check(s, 2'b00, "second level early");
		strobe(1'b0, 1'b1, 32'h0000_4000, s);
		check(s, 2'b00, "first level only");
		strobe(1'b1, 1'b0, 32'h0000_D000, s);
		check(s, 2'b01, "debug interrupt");
		int_level <= 3'd4;
		repeat (2) @(posedge clk);
		check(int_pass, 1'b0, "below critical level");
		int_level <= 3'd5;
		repeat (2) @(posedge clk);
		check(int_pass, 1'b1, "critical served");
		core_rte <= 1'b1;
		@(posedge clk);
		core_rte <= 1'b0;
		repeat (2) @(posedge clk);
		check(int_pass, 1'b0, "handler finished");
	endtask

	// trace buses, trace clock and halted indicator; small package status bus and halted indicator only
	task automatic t_trace();
		logic t0;
		@(posedge clk);
		core_status <= 4'hF;
		core_capture <= 4'hA;
		repeat (2) @(posedge clk);
		check(processor_status_bus, 4'hF, "status copy");
		check(debug_capture_bus, 4'hA, "capture copy");
		check(halted_indicator, 1'b1, "all ones halted");
		check({small_status, small_halted}, 5'h01, "small package");
		t0 = trace_clock_out;
		@(posedge clk);
		check(trace_clock_out, !t0, "trace clock toggles");
		core_status <= 4'hE;
		repeat (2) @(posedge clk);
		check(halted_indicator, 1'b0, "not halted");
	endtask

	// ****************************************
	// clock and main sequence
	// ****************************************
	// 100 MHz core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// reset for three cycles, then every scenario in turn
	initial begin
		sys_rst = 1'b1;
		{cpu_sel, cpu_write, cpu_super, bus_valid, pc_valid, core_rte} = 6'h00;
		{cpu_index, core_status, core_capture, int_level} = 15'h0000;
		{cpu_wdata, bus_addr, bus_data, pc_value} = 128'h0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_serial();
		t_halt();
		t_irq();
		t_trace();
		results();
	end
endmodule
